/* logic/crf_regfile.sv */
// Register file and interrupt state of an 8-bit processor core, as an APB slave.
// Assumes execution logic on pclk drives the op strobes as one-cycle pulses.
//
// How it works
// - Storage totals 208 bits: two banks of eight bytes, four words, two bytes.
// - Main and alternate banks of accumulator, flags, six registers; exchange swaps.
// - Each general register readable alone; active-bank registers also as a 16-bit pair.
// - In a pair, first-named register is high byte, second is low.
// - Vector page register gives upper address byte for vectored interrupts.
// - Refresh tick increments the low seven refresh bits, top bit held.
// - All eight refresh bits appear on the refresh address output.
// - Two independent 16-bit index registers.
// - A 16-bit stack pointer.
// - A 16-bit program counter holding the next fetch address.
// - Two interrupt enable flip-flops record maskable interrupt status.
// - Mode flip-flops: 00 mode 0, 01 unused, 10 mode 1, 11 mode 2.
// - Interrupts sampled only at the last clock of an instruction.
// - Unmaskable interrupt accepted regardless of both enables and wins over maskable.
// - Maskable interrupt accepted only while the main enable is set.
// - One unmaskable response; maskable modes 0, 1 and 2.
// - Mode 2 uses the peripheral vector byte to pick the routine.
// - Unmaskable accept jumps to 0066H; none is taken while a bus request is active.
// - Mode 1 accept jumps to 0038H.
// - Mode 2 table pointer is vector page high, peripheral byte low.
// - Reset and mask op clear both enables, unmask sets both; NMI saves; return restores.
module crf_regfile
	import crf_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        nmi_pin_n,
	input  wire logic        irq_pin_n,
	input  wire logic        instr_last_clk,
	input  wire logic        bus_request_active,
	input  wire logic        irq_mask_op,
	input  wire logic        irq_unmask_op,
	input  wire logic        unmaskable_return_op,
	input  wire logic        mode_set_op,
	input  wire logic [1:0]  mode_set_value,
	input  wire logic        exchange_af_op,
	input  wire logic        exchange_gp_op,
	input  wire logic        refresh_tick,
	input  wire logic        program_counter_inc,
	input  wire logic [7:0]  irq_vector_byte,
	output logic      [15:0] refresh_addr,
	output logic      [15:0] program_counter_out,
	output logic             irq_accept,
	output crf_accept_type   irq_accept_kind,
	output logic      [15:0] irq_table_ptr
);
	logic [7:0]   bank_af [0:1][0:1];
	logic [7:0]   bank_gp [0:1][0:5];
	logic         af_sel;
	logic         gp_sel;
	logic [15:0]  index_reg_x;
	logic [15:0]  index_reg_y;
	logic [15:0]  stack_pointer;
	logic [15:0]  program_counter;
	logic [7:0]   vector_page;
	logic [7:0]   refresh_reg;
	logic         irq_enable_flag_main;
	logic         irq_enable_flag_saved;
	logic         irq_mode_bit_hi;
	logic         irq_mode_bit_lo;
	logic         nmi_pending;
	logic         nmi_prev;
	logic [2:0]   sync_ff [0:1];
	logic         filt_n [0:1];
	logic [31:0]  rd_value;
	logic         rd_hit;

	// Pin synchronisers, three stages, change taken when stages two and three agree
	wire  [1:0]   pins_n = {irq_pin_n, nmi_pin_n};
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : gen_sync
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					sync_ff[g] <= 3'h7;
					filt_n[g]  <= 1'b1;
				end else begin
					sync_ff[g] <= {sync_ff[g][1:0], pins_n[g]};
					if (sync_ff[g][1] == sync_ff[g][2]) begin
						filt_n[g] <= sync_ff[g][2];
					end
				end
			end
		end
	endgenerate

	// Interrupt decisions
	wire          nmi_edge    = nmi_prev & ~filt_n[0];
	wire          int_level   = ~filt_n[1];
	wire          sample      = instr_last_clk & ~bus_request_active;
	wire          take_nmi    = sample & nmi_pending;
	wire          take_int    = sample & ~nmi_pending & int_level & irq_enable_flag_main;
	wire          [1:0] mode  = {irq_mode_bit_hi, irq_mode_bit_lo};

	// Bus decode
	wire          setup_ph    = psel & ~penable;
	wire          wr          = psel & penable & pwrite;
	wire          bank_hit    = paddr[7:6] == 2'b00;
	wire          bank_alt    = paddr[5];
	wire  [2:0]   bank_k      = paddr[4:2];
	wire          wr_bank     = wr & bank_hit;
	wire          af_idx      = af_sel ^ bank_alt;
	wire          gp_idx      = gp_sel ^ bank_alt;
	wire  [2:0]   gp_k        = bank_k - 3'h2;
	wire          pair_hit    = (paddr == CRF_OFS_PAIR_BC) | (paddr == CRF_OFS_PAIR_DE) | (paddr == CRF_OFS_PAIR_HL);
	wire  [2:0]   pair_hi     = {paddr[3:2], 1'b0};
	wire  [2:0]   pair_lo     = {paddr[3:2], 1'b1};
	wire          wr_pair     = wr & pair_hit;
	wire          wr_ctrl     = wr & (paddr == CRF_OFS_CTRL);

	always_comb begin
		rd_value = 32'h0000_0000;
		rd_hit   = 1'b1;
		if (bank_hit) begin
			rd_value[7:0] = (bank_k < 3'h2) ? bank_af[af_idx][bank_k[0]] : bank_gp[gp_idx][gp_k];
		end else if (pair_hit) begin
			rd_value[15:0] = {bank_gp[gp_sel][pair_hi], bank_gp[gp_sel][pair_lo]};
		end else begin
			unique case (paddr)
				CRF_OFS_INDEX_X: rd_value[15:0] = index_reg_x;
				CRF_OFS_INDEX_Y: rd_value[15:0] = index_reg_y;
				CRF_OFS_STACK:   rd_value[15:0] = stack_pointer;
				CRF_OFS_PROG:    rd_value[15:0] = program_counter;
				CRF_OFS_VPAGE:   rd_value[7:0]  = vector_page;
				CRF_OFS_REFRESH: rd_value[7:0]  = refresh_reg;
				CRF_OFS_CTRL: begin
					rd_value[CRF_CTRL_IEF_MAIN]  = irq_enable_flag_main;
					rd_value[CRF_CTRL_IEF_SAVED] = irq_enable_flag_saved;
					rd_value[CRF_CTRL_MODE_LO]   = irq_mode_bit_lo;
					rd_value[CRF_CTRL_MODE_HI]   = irq_mode_bit_hi;
					rd_value[CRF_CTRL_AF_SEL]    = af_sel;
					rd_value[CRF_CTRL_GP_SEL]    = gp_sel;
				end
				CRF_OFS_STATUS: begin
					rd_value[CRF_STAT_NMI_PEND]  = nmi_pending;
					rd_value[CRF_STAT_INT_LEVEL] = int_level;
				end
				CRF_OFS_TABLE:   rd_value[15:0] = irq_table_ptr;
				default:         rd_hit = 1'b0;
			endcase
		end
	end

	assign pready              = 1'b1;
	assign refresh_addr        = {vector_page, refresh_reg};
	assign program_counter_out = program_counter;

	// Read data and error latched in setup, stable through access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (setup_ph) begin
			prdata  <= pwrite ? 32'h0000_0000 : rd_value;
			pslverr <= ~rd_hit;
		end
	end

	// Register banks and bank selects
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bank_af <= '{default: '{default: CRF_RST_BYTE}};
			bank_gp <= '{default: '{default: CRF_RST_BYTE}};
			af_sel  <= 1'b0;
			gp_sel  <= 1'b0;
		end else begin
			if (wr_bank && bank_k < 3'h2) begin
				bank_af[af_idx][bank_k[0]] <= pwdata[7:0];
			end
			if (wr_bank && bank_k >= 3'h2) begin
				bank_gp[gp_idx][gp_k] <= pwdata[7:0];
			end
			if (wr_pair) begin
				bank_gp[gp_sel][pair_hi] <= pwdata[15:8];
				bank_gp[gp_sel][pair_lo] <= pwdata[7:0];
			end
			if (wr_ctrl) begin
				af_sel <= pwdata[CRF_CTRL_AF_SEL];
				gp_sel <= pwdata[CRF_CTRL_GP_SEL];
			end
			if (exchange_af_op) begin
				af_sel <= ~af_sel;
			end
			if (exchange_gp_op) begin
				gp_sel <= ~gp_sel;
			end
		end
	end

	// Word registers and vector page
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			index_reg_x     <= CRF_RST_WORD;
			index_reg_y     <= CRF_RST_WORD;
			stack_pointer   <= CRF_RST_WORD;
			program_counter <= CRF_RST_WORD;
			vector_page     <= CRF_RST_BYTE;
		end else begin
			if (wr && paddr == CRF_OFS_INDEX_X) begin
				index_reg_x <= pwdata[15:0];
			end
			if (wr && paddr == CRF_OFS_INDEX_Y) begin
				index_reg_y <= pwdata[15:0];
			end
			if (wr && paddr == CRF_OFS_STACK) begin
				stack_pointer <= pwdata[15:0];
			end
			if (wr && paddr == CRF_OFS_VPAGE) begin
				vector_page <= pwdata[7:0];
			end
			if (wr && paddr == CRF_OFS_PROG) begin
				program_counter <= pwdata[15:0];
			end else if (program_counter_inc) begin
				program_counter <= program_counter + 16'h0001;
			end
			if (take_nmi) begin
				program_counter <= CRF_NMI_RESTART;
			end else if (take_int && mode == CRF_MODE1) begin
				program_counter <= CRF_MODE1_RESTART;
			end
		end
	end

	// Refresh counter, top bit kept by the increment
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			refresh_reg <= CRF_RST_BYTE;
		end else if (wr && paddr == CRF_OFS_REFRESH) begin
			refresh_reg <= pwdata[7:0];
		end else if (refresh_tick) begin
			refresh_reg <= {refresh_reg[7], refresh_reg[6:0] + CRF_REFRESH_STEP};
		end
	end

	// Enable and mode flip-flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_enable_flag_main  <= 1'b0;
			irq_enable_flag_saved <= 1'b0;
			irq_mode_bit_hi       <= 1'b0;
			irq_mode_bit_lo       <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				irq_enable_flag_main  <= pwdata[CRF_CTRL_IEF_MAIN];
				irq_enable_flag_saved <= pwdata[CRF_CTRL_IEF_SAVED];
			end
			if (wr_ctrl && {pwdata[CRF_CTRL_MODE_HI], pwdata[CRF_CTRL_MODE_LO]} != CRF_UNUSED) begin
				irq_mode_bit_hi <= pwdata[CRF_CTRL_MODE_HI];
				irq_mode_bit_lo <= pwdata[CRF_CTRL_MODE_LO];
			end
			if (mode_set_op && mode_set_value != CRF_UNUSED) begin
				irq_mode_bit_hi <= mode_set_value[1];
				irq_mode_bit_lo <= mode_set_value[0];
			end
			if (irq_mask_op) begin
				irq_enable_flag_main  <= 1'b0;
				irq_enable_flag_saved <= 1'b0;
			end else if (irq_unmask_op) begin
				irq_enable_flag_main  <= 1'b1;
				irq_enable_flag_saved <= 1'b1;
			end else if (unmaskable_return_op) begin
				irq_enable_flag_main <= irq_enable_flag_saved;
			end
			if (take_nmi) begin
				irq_enable_flag_saved <= irq_enable_flag_main;
				irq_enable_flag_main  <= 1'b0;
			end else if (take_int) begin
				irq_enable_flag_main  <= 1'b0;
				irq_enable_flag_saved <= 1'b0;
			end
		end
	end

	// Acceptance, pending unmaskable edge, table pointer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			nmi_prev        <= 1'b1;
			nmi_pending     <= 1'b0;
			irq_accept      <= 1'b0;
			irq_accept_kind <= CRF_ACC_NONE;
			irq_table_ptr   <= CRF_RST_WORD;
		end else begin
			nmi_prev    <= filt_n[0];
			nmi_pending <= nmi_edge | (nmi_pending & ~take_nmi);
			irq_accept  <= take_nmi | take_int;
			if (take_nmi) begin
				irq_accept_kind <= CRF_ACC_NMI;
			end else if (take_int) begin
				irq_accept_kind <= CRF_ACC_INT;
			end else begin
				irq_accept_kind <= CRF_ACC_NONE;
			end
			if (take_int && mode == CRF_MODE2) begin
				irq_table_ptr <= {vector_page, irq_vector_byte};
			end
		end
	end

	// Storage: 16 banked bytes, index, stack, program words, page and refresh make 208 bits
endmodule : crf_regfile

/* logic/crf_pkg.sv */
// Constants of the processor register file and interrupt-state block.
// Assumes a 32-bit APB slave with byte addresses in paddr[7:0].
package crf_pkg;
	typedef enum logic [1:0] {
		CRF_MODE0  = 2'b00,
		CRF_UNUSED = 2'b01,
		CRF_MODE1  = 2'b10,
		CRF_MODE2  = 2'b11
	} crf_mode_type;

	typedef enum logic [1:0] {
		CRF_ACC_NONE = 2'b00,
		CRF_ACC_NMI  = 2'b01,
		CRF_ACC_INT  = 2'b10
	} crf_accept_type;

	localparam logic [7:0]  CRF_OFS_ACTIVE  = 8'h00;
	localparam logic [7:0]  CRF_OFS_ALT     = 8'h20;
	localparam logic [7:0]  CRF_OFS_PAIR_BC = 8'h40;
	localparam logic [7:0]  CRF_OFS_PAIR_DE = 8'h44;
	localparam logic [7:0]  CRF_OFS_PAIR_HL = 8'h48;
	localparam logic [7:0]  CRF_OFS_INDEX_X = 8'h4C;
	localparam logic [7:0]  CRF_OFS_INDEX_Y = 8'h50;
	localparam logic [7:0]  CRF_OFS_STACK   = 8'h54;
	localparam logic [7:0]  CRF_OFS_PROG    = 8'h58;
	localparam logic [7:0]  CRF_OFS_VPAGE   = 8'h5C;
	localparam logic [7:0]  CRF_OFS_REFRESH = 8'h60;
	localparam logic [7:0]  CRF_OFS_CTRL    = 8'h64;
	localparam logic [7:0]  CRF_OFS_STATUS  = 8'h68;
	localparam logic [7:0]  CRF_OFS_TABLE   = 8'h6C;

	localparam int          CRF_CTRL_IEF_MAIN  = 0;
	localparam int          CRF_CTRL_IEF_SAVED = 1;
	localparam int          CRF_CTRL_MODE_LO   = 2;
	localparam int          CRF_CTRL_MODE_HI   = 3;
	localparam int          CRF_CTRL_AF_SEL    = 4;
	localparam int          CRF_CTRL_GP_SEL    = 5;
	localparam int          CRF_STAT_NMI_PEND  = 0;
	localparam int          CRF_STAT_INT_LEVEL = 1;

	localparam logic [15:0] CRF_NMI_RESTART  = 16'h0066;
	localparam logic [15:0] CRF_MODE1_RESTART = 16'h0038;
	localparam logic [15:0] CRF_RST_WORD     = 16'h0000;
	localparam logic [7:0]  CRF_RST_BYTE     = 8'h00;
	localparam logic [6:0]  CRF_REFRESH_STEP = 7'h01;
endpackage : crf_pkg

/* verification/crf_chk.sv */
// Assertion checker for the register file and interrupt-state block.
// Assumes it is bound to crf_regfile and sees only its ports.
module crf_chk
	import crf_pkg::*;
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic        instr_last_clk,
	input wire logic        bus_request_active,
	input wire logic        refresh_tick,
	input wire logic        program_counter_inc,
	input wire logic [15:0] refresh_addr,
	input wire logic [15:0] program_counter_out,
	input wire logic        irq_accept,
	input wire crf_accept_type irq_accept_kind
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire apb_wr = psel && penable && pwrite;

	property p_accept_pulse; irq_accept |=> !irq_accept; endproperty
	a_accept_pulse: assert property (p_accept_pulse) else $error("accept pulse too long");
	property p_accept_cause; irq_accept |-> $past(instr_last_clk) && !$past(bus_request_active); endproperty
	a_accept_cause: assert property (p_accept_cause) else $error("accept without boundary");
	property p_busreq; instr_last_clk && bus_request_active |=> !irq_accept; endproperty
	a_busreq: assert property (p_busreq) else $error("accept during bus request");
	property p_nmi_pc;
		irq_accept && irq_accept_kind == CRF_ACC_NMI |-> program_counter_out == CRF_NMI_RESTART;
	endproperty
	a_nmi_pc: assert property (p_nmi_pc) else $error("bad unmaskable restart");
	property p_kind; irq_accept |-> irq_accept_kind inside {CRF_ACC_NMI, CRF_ACC_INT}; endproperty
	a_kind: assert property (p_kind) else $error("bad accept kind");
	property p_ref_inc;
		refresh_tick && !apb_wr |=> refresh_addr[6:0] == $past(refresh_addr[6:0]) + 7'h01
			&& refresh_addr[7] == $past(refresh_addr[7]);
	endproperty
	a_ref_inc: assert property (p_ref_inc) else $error("bad refresh step");
	property p_ref_hold; !refresh_tick && !apb_wr |=> $stable(refresh_addr[7:0]); endproperty
	a_ref_hold: assert property (p_ref_hold) else $error("refresh moved");
	property p_page_hold; !apb_wr |=> $stable(refresh_addr[15:8]); endproperty
	a_page_hold: assert property (p_page_hold) else $error("vector page moved");
	property p_counter_step;
		program_counter_inc && !instr_last_clk && !apb_wr
			|=> program_counter_out == $past(program_counter_out) + 16'h0001;
	endproperty
	a_counter_step: assert property (p_counter_step) else $error("bad program counter step");
endmodule : crf_chk

bind crf_regfile crf_chk u_chk (.*);

/* verification/crf_periph.sv */
// Model of the interrupting peripherals: two maskable requesters and one unmaskable source.
// Assumes the bench drives the request levels at rising clock edges.
module crf_periph (
	input  wire logic [1:0] req_irq,
	input  wire logic       req_nmi,
	input  wire logic [7:0] vec,
	output logic            nmi_pin_n,
	output logic            irq_pin_n,
	output logic      [7:0] irq_vector_byte
);
	timeunit 1ns;
	timeprecision 1ns;
	assign nmi_pin_n = ~req_nmi;
	assign irq_pin_n = ~|req_irq;
	assign irq_vector_byte = |req_irq ? vec : ~vec;
endmodule : crf_periph

/* verification/testbench.sv */
// Self-checking bench for the register file over APB plus interrupt sequences.
// Assumes crf_regfile, crf_periph and the bound checker are compiled first.
module testbench;
	import crf_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
	logic              nmi_n, irq_n, acc, req_nmi, ilc, breq;
	logic        [7:0] paddr, vec, ivb, ops;
	logic        [1:0] req_irq, mode_v;
	logic       [31:0] pwdata, prdata, rdat;
	logic       [15:0] raddr, prog_cnt, tptr;
	crf_accept_type    kind;
	int                err_count, check_count, i;
	logic        [1:0] mv[4] = '{2'b00, 2'b10, 2'b11, 2'b01};
	logic        [1:0] me[4] = '{2'b00, 2'b10, 2'b11, 2'b11};

	crf_regfile dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.nmi_pin_n(nmi_n), .irq_pin_n(irq_n), .instr_last_clk(ilc), .bus_request_active(breq),
		.irq_mask_op(ops[0]), .irq_unmask_op(ops[1]), .unmaskable_return_op(ops[2]),
		.mode_set_op(ops[3]), .mode_set_value(mode_v), .exchange_af_op(ops[4]), .exchange_gp_op(ops[5]),
		.refresh_tick(ops[6]), .program_counter_inc(ops[7]), .irq_vector_byte(ivb), .refresh_addr(raddr),
		.program_counter_out(prog_cnt), .irq_accept(acc), .irq_accept_kind(kind), .irq_table_ptr(tptr));
	crf_periph u_periph (.req_irq(req_irq), .req_nmi(req_nmi), .vec(vec), .nmi_pin_n(nmi_n),
		.irq_pin_n(irq_n), .irq_vector_byte(ivb));

	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end

	task give_verdict;
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : give_verdict

	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e) begin
			$display("[ERR] %s expected %h seen %h", n, e, s);
			err_count++;
		end
	endtask : chk

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task rdc(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk($sformatf("reg %h", a), rdat, e);
	endtask : rdc

	task op(input int k);
		@(posedge pclk);
		ops[k] <= 1'b1;
		@(posedge pclk);
		ops[k] <= 1'b0;
		@(negedge pclk);
	endtask : op

	task fire(input logic e, input logic [1:0] k);
		@(posedge pclk);
		ilc <= 1'b1;
		@(posedge pclk);
		ilc <= 1'b0;
		@(negedge pclk);
		chk("accept", acc, e);
		if (e)
			chk("kind", kind, k);
	endtask : fire

	task ctrl(input logic [1:0] e);
		apb(1'b0, CRF_OFS_CTRL, 32'h0);
		chk("enables", rdat[1:0], e);
	endtask : ctrl

	initial begin
		{psel, penable, pwrite, ops, req_nmi, req_irq, ilc, breq, mode_v} = '0;
		paddr = 8'h00;
		pwdata = 32'h0;
		vec = 8'h34;
		presetn = 1'b0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		for (i = 0; i < 4; i++) rdc(CRF_OFS_PROG + 8'(4 * i), 32'h0);
		$display("test reset done");
		for (i = 0; i < 16; i++) apb(1'b1, 8'(4 * i), 32'h11 + 32'(4 * i));
		rdc(CRF_OFS_PAIR_BC, 32'h191D);
		op(4);
		rdc(8'h00, 32'h31);
		rdc(8'h20, 32'h11);
		op(5);
		rdc(CRF_OFS_PAIR_BC, 32'h393D);
		apb(1'b1, CRF_OFS_PAIR_DE, 32'hABCD);
		rdc(8'h10, 32'hAB);
		rdc(8'h14, 32'hCD);
		for (i = 0; i < 3; i++) begin
			apb(1'b1, CRF_OFS_INDEX_X + 8'(4 * i), 32'hFFFFA5C0 + 32'(i));
			rdc(CRF_OFS_INDEX_X + 8'(4 * i), 32'h0000A5C0 + 32'(i));
		end
		apb(1'b1, CRF_OFS_PROG, 32'h00FF);
		op(7);
		chk("program counter", prog_cnt, 32'h0100);
		apb(1'b1, CRF_OFS_REFRESH, 32'hFF);
		apb(1'b1, CRF_OFS_VPAGE, 32'h12);
		op(6);
		chk("refresh_addr", raddr, 32'h1280);
		rdc(CRF_OFS_REFRESH, 32'h80);
		apb(1'b0, 8'h70, 32'h0);
		chk("slverr", rerr, 32'h1);
		chk("pready", pready, 32'h1);
		$display("test registers done");
		for (i = 0; i < 4; i++) begin
			@(posedge pclk) mode_v <= mv[i];
			op(3);
			apb(1'b0, CRF_OFS_CTRL, 32'h0);
			chk("mode", rdat[3:2], me[i]);
		end
		op(1);
		ctrl(2'b11);
		op(0);
		ctrl(2'b00);
		@(posedge pclk) req_irq <= 2'b01;
		repeat (6) @(posedge pclk);
		fire(1'b0, CRF_ACC_NONE);
		@(posedge pclk) mode_v <= 2'b10;
		op(3);
		op(1);
		@(posedge pclk) req_nmi <= 1'b1;
		repeat (6) @(posedge pclk);
		fire(1'b1, CRF_ACC_NMI);
		chk("program counter", prog_cnt, 32'h0066);
		ctrl(2'b10);
		fire(1'b0, CRF_ACC_NONE);
		op(2);
		ctrl(2'b11);
		fire(1'b1, CRF_ACC_INT);
		chk("program counter", prog_cnt, 32'h0038);
		@(posedge pclk) mode_v <= 2'b11;
		op(3);
		op(1);
		@(posedge pclk) req_irq <= 2'b10;
		fire(1'b1, CRF_ACC_INT);
		chk("table", tptr, 32'h1234);
		rdc(CRF_OFS_TABLE, 32'h1234);
		$display("test interrupts done");
		@(posedge pclk) req_nmi <= 1'b0;
		req_irq <= 2'b00;
		repeat (6) @(posedge pclk);
		req_nmi <= 1'b1;
		breq <= 1'b1;
		repeat (6) @(posedge pclk);
		fire(1'b0, CRF_ACC_NONE);
		rdc(CRF_OFS_STATUS, 32'h1);
		@(posedge pclk) breq <= 1'b0;
		fire(1'b1, CRF_ACC_NMI);
		$display("test bus request done");
		@(posedge pclk) mode_v <= 2'b00;
		op(3);
		op(1);
		@(posedge pclk) req_irq <= 2'b01;
		repeat (6) @(posedge pclk);
		fire(1'b1, CRF_ACC_INT);
		chk("program counter", prog_cnt, 32'h0066);
		chk("table", tptr, 32'h1234);
		$display("test mode zero done");
		give_verdict();
	end

	// Whole run needs well under a thousand cycles
	initial begin
		#2000000;
		err_count++;
		give_verdict();
	end
endmodule : testbench
